// >>> core/dma_pkg.sv
// constants, codes and carrier types of the multichannel transfer engine
package dma_pkg;
	// ==========================================
	// geometry
	localparam int NUM_CH = 7;
	localparam int CH_W = 3;
	localparam int NUM_FUNC = 9;
	localparam logic [7:0] SEL_LIMIT = 8'h07;
	localparam logic [3:0] FUNC_LIMIT = 4'h9;
	// ==========================================
	// register port offsets
	localparam logic [7:0] REG_SELECT = 8'h00;
	localparam logic [7:0] REG_FUNCTION = 8'h01;
	localparam logic [7:0] REG_WRAP = 8'h02;
	localparam logic [7:0] REG_BASE_H = 8'h03;
	localparam logic [7:0] REG_BASE_L = 8'h04;
	localparam logic [7:0] REG_SIZE_H = 8'h05;
	localparam logic [7:0] REG_SIZE_L = 8'h06;
	localparam logic [7:0] REG_OFF_H = 8'h07;
	localparam logic [7:0] REG_OFF_L = 8'h08;
	localparam logic [7:0] REG_ENABLES = 8'h09;
	localparam logic [7:0] REG_FLAGS = 8'h0A;
	localparam logic [7:0] REG_HALF_FLAGS = 8'h0B;
	// ==========================================
	// fields and values
	localparam int FULL_IE_BIT = 7;
	localparam int HALF_IE_BIT = 6;
	localparam logic [7:0] WRAP_ON = 8'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam logic [15:0] ZERO_WORD = 16'h0000;
	localparam logic [15:0] ONE_WORD = 16'h0001;
	// ==========================================
	// transfer function codes
	localparam logic [3:0] F_RAM_TO_ENC = 4'h0;
	localparam logic [3:0] F_ENC_TO_RAM = 4'h1;
	localparam logic [3:0] F_RAM_TO_CRC = 4'h2;
	localparam logic [3:0] F_RAM_TO_SPI = 4'h3;
	localparam logic [3:0] F_SPI_TO_RAM = 4'h4;
	localparam logic [3:0] F_RAM_TO_KEY = 4'h5;
	localparam logic [3:0] F_RAM_TO_BLOCK = 4'h6;
	localparam logic [3:0] F_RAM_TO_XOR = 4'h7;
	localparam logic [3:0] F_OUT_TO_RAM = 4'h8;
	// ==========================================
	// carriers
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_bus_t;
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic re;
		logic we;
	} ram_req_t;
	typedef struct packed {
		logic [3:0] code;
		logic [7:0] wdata;
		logic rd;
		logic wr;
	} per_req_t;
	typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_CAPTURE, ST_ACK} xfer_state_t;
	typedef struct packed {
		xfer_state_t state;
		logic [CH_W-1:0] cur;
		logic [7:0] sel;
		logic [NUM_CH-1:0][7:0] func;
		logic [NUM_CH-1:0] wrap;
		logic [NUM_CH-1:0][15:0] base;
		logic [NUM_CH-1:0][15:0] size;
		logic [NUM_CH-1:0][15:0] off;
		logic [NUM_CH-1:0] en;
		logic [NUM_CH-1:0] flags;
		logic [NUM_CH-1:0] half;
		logic [7:0] rdata;
		ram_req_t ram;
		per_req_t per;
		logic flag_out;
	} engine_state_t;
endpackage

// >>> core/transfer_engine.sv
// seven-channel byte transfer engine between data ram and peripheral data registers
// ==========================================
// Notes on behaviour
// RL1: seven channels, nine selectable transfer functions
// RL2: enabled channel moves bytes without processor help
// RL3: per-channel function, mode, base, size, offset
// RL4: half-length and full-length flags per channel
// RL5: select register steers per-channel register accesses
// RL6: codes 5,6,8: key, block, output
// RL7: code 7 feeds cipher xor input
// RL8: function bit 7 enables completion interrupt
// RL9: mode 0x01 enables wrap, zero disables
// RL10: base address from high and low
// RL11: length from size high and low
// RL12: software clears offsets before enabling
// RL13: key channel uses low size, wrapping
// RL14: enable bit per channel, zero disables all
// RL15: one flag per channel, cleared by zero
// RL16: disable, configure, clear flags, then enable
// RL17: vector placed directly ahead of ciphertext
// RL18: output channel completion ends cipher operation
// RL19: dataflow 0x00 three channels, 0x02 four
// RL20: output bytes read only when offered
// RL21: wrap resets offset, otherwise stop and flag
// RL22: pending requests served bytewise, lowest index first
module transfer_engine (
	input wire logic clk,
	input wire logic arst_n,
	input dma_pkg::reg_bus_t bus,
	output logic [7:0] rdata_r,
	output dma_pkg::ram_req_t ram_r,
	input wire logic [7:0] ram_rdata,
	output dma_pkg::per_req_t per_r,
	input wire logic [7:0] per_rdata,
	input wire logic [8:0] per_req,
	output logic flag_out_r
);
	import dma_pkg::*;

	engine_state_t s_r;
	engine_state_t s_nxt;
	logic [NUM_CH-1:0] elig;
	logic [CH_W-1:0] pick;
	logic any_elig;
	logic sel_ok;
	logic [CH_W-1:0] si;
	logic [15:0] next_off;
	logic [15:0] cur_size;
	logic [3:0] cur_code;

	function automatic logic from_periph(input logic [3:0] code);
		from_periph = (code == F_ENC_TO_RAM) || (code == F_SPI_TO_RAM) || (code == F_OUT_TO_RAM);
	endfunction

	// ==========================================
	// eligibility and fixed-order arbitration
	generate
		for (genvar g = 0; g < NUM_CH; g++) begin : g_elig
			// a size of zero or an unknown code leaves the channel idle
			assign elig[g] = s_r.en[g] && (s_r.size[g] != ZERO_WORD) && (s_r.func[g][3:0] < FUNC_LIMIT)
				&& per_req[s_r.func[g][3:0]]; // RL1 RL2
		end
	endgenerate

	always_comb begin
		pick = '0;
		for (int i = NUM_CH - 1; i >= 0; i--) begin
			if (elig[i]) begin
				pick = CH_W'(i); // RL22
			end
		end
	end

	assign any_elig = |elig;
	assign sel_ok = s_r.sel < SEL_LIMIT;
	assign si = s_r.sel[CH_W-1:0];
	assign cur_code = s_r.func[s_r.cur][3:0];
	assign cur_size = s_r.size[s_r.cur];
	assign next_off = s_r.off[s_r.cur] + ONE_WORD;

	// ==========================================
	// next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = ZERO_BYTE;
		s_nxt.ram.re = 1'b0;
		s_nxt.ram.we = 1'b0;
		s_nxt.per.rd = 1'b0;
		s_nxt.per.wr = 1'b0;
		// software writes; an out-of-range select drops per-channel writes
		if (bus.wr) begin
			case (bus.addr)
				REG_SELECT: s_nxt.sel = bus.wdata; // RL5
				REG_ENABLES: s_nxt.en = bus.wdata[NUM_CH-1:0]; // RL14
				REG_FLAGS: s_nxt.flags = s_r.flags & bus.wdata[NUM_CH-1:0]; // RL15
				REG_HALF_FLAGS: s_nxt.half = s_r.half & bus.wdata[NUM_CH-1:0];
				default: begin
					if (sel_ok) begin
						case (bus.addr)
							REG_FUNCTION: s_nxt.func[si] = bus.wdata; // RL3
							REG_WRAP: s_nxt.wrap[si] = (bus.wdata == WRAP_ON); // RL9
							REG_BASE_H: s_nxt.base[si][15:8] = bus.wdata; // RL10
							REG_BASE_L: s_nxt.base[si][7:0] = bus.wdata; // RL10
							REG_SIZE_H: s_nxt.size[si][15:8] = bus.wdata; // RL11
							REG_SIZE_L: s_nxt.size[si][7:0] = bus.wdata; // RL11
							REG_OFF_H: s_nxt.off[si][15:8] = bus.wdata;
							REG_OFF_L: s_nxt.off[si][7:0] = bus.wdata;
							default: s_nxt.sel = s_r.sel;
						endcase
					end
				end
			endcase
		end
		// software reads, answered in the next cycle; unmapped reads give zero
		if (bus.rd) begin
			case (bus.addr)
				REG_SELECT: s_nxt.rdata = s_r.sel;
				REG_ENABLES: s_nxt.rdata = {1'b0, s_r.en};
				REG_FLAGS: s_nxt.rdata = {1'b0, s_r.flags};
				REG_HALF_FLAGS: s_nxt.rdata = {1'b0, s_r.half};
				default: begin
					if (sel_ok) begin
						case (bus.addr)
							REG_FUNCTION: s_nxt.rdata = s_r.func[si];
							REG_WRAP: s_nxt.rdata = s_r.wrap[si] ? WRAP_ON : ZERO_BYTE;
							REG_BASE_H: s_nxt.rdata = s_r.base[si][15:8];
							REG_BASE_L: s_nxt.rdata = s_r.base[si][7:0];
							REG_SIZE_H: s_nxt.rdata = s_r.size[si][15:8];
							REG_SIZE_L: s_nxt.rdata = s_r.size[si][7:0];
							REG_OFF_H: s_nxt.rdata = s_r.off[si][15:8];
							REG_OFF_L: s_nxt.rdata = s_r.off[si][7:0];
							default: s_nxt.rdata = ZERO_BYTE;
						endcase
					end
				end
			endcase
		end
		// one byte per grant; the lowest eligible channel wins each new grant, so a busy low channel holds off higher ones
		case (s_r.state)
			ST_IDLE: begin
				if (any_elig) begin
					s_nxt.cur = pick; // RL22
					s_nxt.state = ST_ISSUE;
					s_nxt.ram.addr = s_r.base[pick] + s_r.off[pick];
					if (from_periph(s_r.func[pick][3:0])) begin
						s_nxt.per.rd = 1'b1; // RL20
						s_nxt.per.code = s_r.func[pick][3:0];
					end else begin
						s_nxt.ram.re = 1'b1; // RL2
					end
				end
			end
			ST_ISSUE: s_nxt.state = ST_CAPTURE;
			ST_CAPTURE: begin
				s_nxt.state = ST_ACK;
				if (from_periph(cur_code)) begin
					s_nxt.ram.we = 1'b1;
					s_nxt.ram.wdata = per_rdata;
				end else begin
					s_nxt.per.wr = 1'b1; // RL6 RL7 RL19
					s_nxt.per.code = cur_code;
					s_nxt.per.wdata = ram_rdata;
				end
				// hardware updates win over software in this cycle
				s_nxt.off[s_r.cur] = next_off;
				if (next_off == {1'b0, cur_size[15:1]}) begin
					s_nxt.half[s_r.cur] = 1'b1; // RL4
				end
				if (next_off == cur_size) begin
					s_nxt.flags[s_r.cur] = 1'b1; // RL4
					if (s_r.wrap[s_r.cur]) begin
						s_nxt.off[s_r.cur] = ZERO_WORD; // RL21
					end else begin
						s_nxt.en[s_r.cur] = 1'b0; // RL21
					end
				end
			end
			ST_ACK: s_nxt.state = ST_IDLE;
			default: s_nxt.state = ST_IDLE;
		endcase
		s_nxt.flag_out = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			if ((s_nxt.flags[i] && s_nxt.func[i][FULL_IE_BIT]) || (s_nxt.half[i] && s_nxt.func[i][HALF_IE_BIT])) begin
				s_nxt.flag_out = 1'b1; // RL8
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign rdata_r = s_r.rdata;
	assign ram_r = s_r.ram;
	assign per_r = s_r.per;
	assign flag_out_r = s_r.flag_out;

	// ==========================================
	// checks
	sequence seq_read_phase;
		(s_r.state == ST_ISSUE) && (ram_r.re || per_r.rd);
	endsequence
	sequence seq_write_phase;
		(s_r.state == ST_ACK) && (ram_r.we ^ per_r.wr);
	endsequence

	property p_byte_move;
		@(posedge clk) disable iff (!arst_n)
		seq_read_phase |-> ##2 seq_write_phase;
	endproperty
	a_byte_move: assert property (p_byte_move) else $error("byte move did not complete in two cycles"); // RL2

	property p_grant_lowest;
		@(posedge clk) disable iff (!arst_n)
		(s_r.state == ST_IDLE) && any_elig |=> (s_r.cur == $past(pick)) and seq_read_phase;
	endproperty
	a_grant_lowest: assert property (p_grant_lowest) else $error("grant not given to lowest requester"); // RL22

	property p_to_periph_source;
		@(posedge clk) disable iff (!arst_n)
		per_r.wr |-> $past(ram_r.re, 2) && !from_periph(per_r.code) && (per_r.wdata == $past(ram_rdata));
	endproperty
	a_to_periph_source: assert property (p_to_periph_source) else $error("peripheral write not fed from ram"); // RL6

	property p_out_read_offered;
		@(posedge clk) disable iff (!arst_n)
		per_r.rd |-> from_periph(per_r.code) && ((($past(per_req) >> per_r.code) & 9'h001) != 9'h000);
	endproperty
	a_out_read_offered: assert property (p_out_read_offered) else $error("peripheral read without request"); // RL20

	property p_wrap_restart;
		@(posedge clk) disable iff (!arst_n)
		(s_r.state == ST_CAPTURE) && (next_off == cur_size) && s_r.wrap[s_r.cur]
			|=> (s_r.off[$past(s_r.cur)] == ZERO_WORD) && s_r.flags[$past(s_r.cur)];
	endproperty
	a_wrap_restart: assert property (p_wrap_restart) else $error("wrap did not restart offset"); // RL21

	property p_stop_at_size;
		@(posedge clk) disable iff (!arst_n)
		(s_r.state == ST_CAPTURE) && (next_off == cur_size) && !s_r.wrap[s_r.cur]
			|=> !s_r.en[$past(s_r.cur)] && s_r.flags[$past(s_r.cur)];
	endproperty
	a_stop_at_size: assert property (p_stop_at_size) else $error("channel did not stop at size"); // RL4

	property p_flag_clear;
		@(posedge clk) disable iff (!arst_n)
		bus.wr && (bus.addr == REG_FLAGS) && (bus.wdata == ZERO_BYTE) && (s_r.state != ST_CAPTURE)
			|=> (s_r.flags == '0);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flags not cleared by zero write"); // RL15

	property p_enable_readback;
		@(posedge clk) disable iff (!arst_n)
		bus.rd && (bus.addr == REG_ENABLES) |=> (rdata_r == {1'b0, $past(s_r.en)})
			##1 (rdata_r == ZERO_BYTE || $past(bus.rd));
	endproperty
	a_enable_readback: assert property (p_enable_readback) else $error("enable readback wrong"); // RL14

	property p_select_steers;
		@(posedge clk) disable iff (!arst_n)
		bus.wr && (bus.addr == REG_BASE_L) && sel_ok |=> (s_r.base[$past(si)][7:0] == $past(bus.wdata));
	endproperty
	a_select_steers: assert property (p_select_steers) else $error("base write not steered by select"); // RL5

	property p_wrap_mode;
		@(posedge clk) disable iff (!arst_n)
		bus.wr && (bus.addr == REG_WRAP) && sel_ok |=> (s_r.wrap[$past(si)] == ($past(bus.wdata) == WRAP_ON));
	endproperty
	a_wrap_mode: assert property (p_wrap_mode) else $error("wrap mode not taken"); // RL9

	property p_full_irq;
		@(posedge clk) disable iff (!arst_n)
		(s_r.flags[s_r.cur] && s_r.func[s_r.cur][FULL_IE_BIT]) |-> flag_out_r;
	endproperty
	a_full_irq: assert property (p_full_irq) else $error("enabled completion flag not signalled"); // RL8
endmodule

// >>> test/periph_ram_model.sv
// data ram and peripheral byte source facing the transfer engine
module periph_ram_model (
	input wire logic clk,
	input wire logic arst_n,
	input dma_pkg::ram_req_t ram_r,
	output logic [7:0] ram_rdata,
	input dma_pkg::per_req_t per_r,
	output logic [7:0] per_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	import dma_pkg::*;
	logic [7:0] mem [256];
	logic [7:0] src;
	initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
	// ==========================================
	// read data stand one cycle only; garbled after so a late sample shows
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			src <= 8'hC0;
			ram_rdata <= 8'hFF;
			per_rdata <= 8'hFF;
		end else begin
			ram_rdata <= ram_r.re ? mem[ram_r.addr[7:0]] : ~ram_rdata;
			if (ram_r.we) mem[ram_r.addr[7:0]] <= ram_r.wdata;
			per_rdata <= per_r.rd ? src : ~per_rdata;
			if (per_r.rd) src <= src + 8'h01;
		end
	end
endmodule

// >>> test/tb_transfer_engine.sv
// self-checking bench of the transfer engine against a queue model
module tb_transfer_engine;
	timeunit 1ns;
	timeprecision 1ps;
	import dma_pkg::*;
	// ==========================================
	// signals
	logic clk, arst_n, flag_out_r, rnd;
	reg_bus_t bus;
	logic [7:0] rdata_r, ram_rdata, per_rdata, src, v;
	logic [7:0] shadow [256];
	logic [23:0] x;
	logic [15:0] sz;
	ram_req_t ram_r;
	per_req_t per_r;
	logic [8:0] per_req, stall;
	int credit [9];
	int eq [9][$];
	int order [$];
	int bad_count, checks_done;
	transfer_engine uut (.clk(clk), .arst_n(arst_n), .bus(bus), .rdata_r(rdata_r), .ram_r(ram_r),
		.ram_rdata(ram_rdata), .per_r(per_r), .per_rdata(per_rdata), .per_req(per_req), .flag_out_r(flag_out_r));
	periph_ram_model far (.clk(clk), .arst_n(arst_n), .ram_r(ram_r), .ram_rdata(ram_rdata), .per_r(per_r),
		.per_rdata(per_rdata));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	always_comb for (int c = 0; c < 9; c++) per_req[c] = credit[c] > 0 && !stall[c];
	// ==========================================
	// monitor: every moved byte against the model queue of its function
	always @(posedge clk) begin
		stall <= rnd ? 9'($urandom) : 9'h000;
		if (arst_n && (per_r.wr | ram_r.we) === 1'b1) begin
			credit[per_r.code] <= credit[per_r.code] - 1;
			order.push_back(per_r.code);
			cmp("direction", 24'(per_r.code inside {4'h1, 4'h4, 4'h8}), 24'(ram_r.we));
			cmp("byte_expected", 24'h000001, 24'(eq[per_r.code].size() > 0));
			// ram mirror follows the expected bytes, so later reads of written cells stay predictable
			if (eq[per_r.code].size() > 0) begin
				x = 24'(eq[per_r.code].pop_front());
				cmp("moved_byte", x, {ram_r.addr, per_r.wr ? per_r.wdata : ram_r.wdata});
				if (ram_r.we) shadow[x[15:8]] = x[7:0];
			end
		end
	end
	// ==========================================
	// tasks
	task automatic cmp(input string n, input logic [23:0] e, g);
		checks_done++;
		if (g !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e, input string n);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus.rd <= 1'b0;
		#1;
		cmp(n, 24'(e), 24'(rdata_r));
	endtask
	// program one channel and queue the bytes it must move; extra credit shows a missed stop
	task automatic setup(input int ch, input logic [7:0] fn, md, input logic [15:0] b, s, input int n);
		logic [15:0] a;
		logic [3:0] c;
		c = fn[3:0];
		wr(REG_SELECT, 8'(ch));
		wr(REG_FUNCTION, fn);
		wr(REG_WRAP, md);
		wr(REG_BASE_H, b[15:8]);
		wr(REG_BASE_L, b[7:0]);
		wr(REG_SIZE_H, s[15:8]);
		wr(REG_SIZE_L, s[7:0]);
		wr(REG_OFF_H, ZERO_BYTE);
		wr(REG_OFF_L, ZERO_BYTE);
		for (int i = 0; i < n; i++) begin
			a = b + 16'(i % int'(s));
			v = shadow[a[7:0]];
			if (c inside {4'h1, 4'h4, 4'h8}) begin
				v = src;
				src++;
			end
			eq[c].push_back({a, v});
		end
		credit[c] = n + (md == WRAP_ON ? 0 : 2);
	endtask
	task automatic drain();
		int p;
		for (int n = 0; n < 3000; n++) begin
			p = 0;
			for (int c = 0; c < 9; c++) p += eq[c].size();
			if (p == 0) break;
			@(posedge clk);
		end
		cmp("pending_bytes", 24'h000000, 24'(p));
		repeat (12) @(posedge clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==========================================
	// sequence
	initial begin
		#200000;
		bad_count++;
		report_and_stop();
	end
	initial begin
		void'($urandom(1));
		arst_n = 1'b0;
		rnd = 1'b0;
		stall = 9'h000;
		src = 8'hC0;
		bus = '0;
		for (int c = 0; c < 9; c++) credit[c] = 0;
		for (int i = 0; i < 256; i++) shadow[i] = 8'(i) ^ 8'h5A;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		for (int r = 0; r < 12; r++) rd(8'(r), ZERO_BYTE, "reset_value");
		for (int ch = 0; ch < 8; ch++) begin
			wr(REG_SELECT, 8'(ch));
			wr(REG_BASE_L, 8'(ch * 37 + 5));
		end
		for (int ch = 0; ch < 8; ch++) begin
			wr(REG_SELECT, 8'(ch));
			rd(REG_BASE_L, ch < NUM_CH ? 8'(ch * 37 + 5) : ZERO_BYTE, "steered_base");
		end
		wr(REG_SELECT, ZERO_BYTE);
		wr(REG_WRAP, 8'h03);
		rd(REG_WRAP, ZERO_BYTE, "wrap_mode");
		rd(8'h3C, ZERO_BYTE, "unmapped");
		// wrapped key, block input and output channel all pending together
		setup(0, {4'h0, F_RAM_TO_KEY}, WRAP_ON, 16'h0120, 16'h0003, 7);
		setup(1, {4'h0, F_RAM_TO_BLOCK}, ZERO_BYTE, 16'h0200, 16'h0010, 16);
		setup(2, {4'h8, F_OUT_TO_RAM}, ZERO_BYTE, 16'h0300, 16'h0010, 16);
		wr(REG_FLAGS, ZERO_BYTE);
		wr(REG_HALF_FLAGS, ZERO_BYTE);
		wr(REG_ENABLES, 8'h07);
		drain();
		for (int i = 0; i < 39; i++) cmp("grant_order", i < 7 ? 24'h5 : i < 23 ? 24'h6 : 24'h8, 24'(order[i]));
		cmp("flag_line", 24'h000001, 24'(flag_out_r));
		rd(REG_ENABLES, 8'h01, "enables_after");
		rd(REG_FLAGS, 8'h07, "full_flags");
		rd(REG_HALF_FLAGS, 8'h07, "half_flags");
		rd(REG_OFF_L, 8'h10, "stop_offset");
		wr(REG_ENABLES, ZERO_BYTE);
		wr(REG_FLAGS, 8'h03);
		rd(REG_FLAGS, 8'h03, "flags_cleared");
		cmp("flag_line_off", 24'h000000, 24'(flag_out_r));
		rd(REG_ENABLES, ZERO_BYTE, "all_off");
		// every function code in turn, with the peripheral stalling at random
		rnd = 1'b1;
		for (int c = 0; c < NUM_FUNC; c++) begin
			sz = 16'(2 + $urandom_range(5));
			setup(c % NUM_CH, {4'h0, 4'(c)}, ZERO_BYTE, 16'($urandom), sz, int'(sz));
			wr(REG_FLAGS, ZERO_BYTE);
			wr(REG_ENABLES, 8'(1 << (c % NUM_CH)));
			drain();
			rd(REG_ENABLES, ZERO_BYTE, "stopped");
			rd(REG_FLAGS, 8'(1 << (c % NUM_CH)), "done_flag");
		end
		rnd = 1'b0;
		// chained decryption: xor channel starts at the vector placed just ahead of the ciphertext
		wr(REG_ENABLES, ZERO_BYTE);
		setup(0, {4'h0, F_RAM_TO_KEY}, WRAP_ON, 16'h0420, 16'h0010, 16);
		setup(1, {4'h0, F_RAM_TO_BLOCK}, ZERO_BYTE, 16'h0450, 16'h0010, 16);
		setup(2, {4'h0, F_RAM_TO_XOR}, ZERO_BYTE, 16'h0440, 16'h0010, 16);
		setup(3, {4'h8, F_OUT_TO_RAM}, ZERO_BYTE, 16'h0480, 16'h0010, 16);
		wr(REG_FLAGS, ZERO_BYTE);
		wr(REG_ENABLES, 8'h0F);
		drain();
		rd(REG_FLAGS, 8'h0F, "chain_flags");
		cmp("chain_done", 24'h000001, 24'(flag_out_r));
		wr(REG_ENABLES, ZERO_BYTE);
		report_and_stop();
	end
endmodule
